// ---- cfad_pkg.sv ----
// Package: constants for the flags and arithmetic datapath
`default_nettype none
package cfad_pkg;
    // ****************************************
    // Condition code bit positions
    // ****************************************
    localparam int BIT_I = 7;
    localparam int BIT_UI = 6;
    localparam int BIT_H = 5;
    localparam int BIT_U = 4;
    localparam int BIT_N = 3;
    localparam int BIT_Z = 2;
    localparam int BIT_V = 1;
    localparam int BIT_C = 0;
    localparam logic [7:0] CCR_RESET = 8'h80;
    localparam logic [7:0] CCR_IMASK = 8'h80;
    // ****************************************
    // Operand sizes and half-carry positions
    // ****************************************
    localparam logic [1:0] SZ_B = 2'h0;
    localparam logic [1:0] SZ_W = 2'h1;
    localparam logic [1:0] SZ_L = 2'h2;
    localparam int HC_B = 4;
    localparam int HC_W = 12;
    localparam int HC_L = 28;
    // ****************************************
    // Operation codes
    // ****************************************
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ADD = 4'h1,
        OP_ADD_WITH_EXTEND = 4'h2,
        OP_SUB = 4'h3,
        OP_SUBTRACT_WITH_EXTEND = 4'h4,
        OP_CMP = 4'h5,
        OP_NEG = 4'h6,
        OP_ZERO_EXTEND_OP = 4'h7,
        OP_SIGN_EXTEND_OP = 4'h8,
        OP_DIVS = 4'h9,
        OP_SHIFT = 4'ha,
        OP_BITOP = 4'hb,
        OP_LDC = 4'hc,
        OP_AND_INTO_CONTROL = 4'hd,
        OP_ORC = 4'he,
        OP_XOR_INTO_CONTROL = 4'hf
    } cfad_op_e;
endpackage : cfad_pkg
`default_nettype wire

// ---- cfad_core.sv ----
// Design: flags register and arithmetic datapath of the core
//
// What this block does
// - Mask bit set refuses all interrupts but non-maskable; mask is one after reset.
// - Non-maskable interrupt is always accepted regardless of mask bit.
// - Starting exception handling forces the mask bit to one.
// - Bits 6 and 4 are user bits, read and written by control ops.
// - Byte add, add_with_extend, sub, subtract_with_extend, compare, negate: half-carry from bit 3.
// - Word add, sub, compare, negate: half-carry from bit 11.
// - Longword add, sub, compare, negate: half-carry from bit 27.
// - Negative flag takes the result's most significant bit; divide takes dividend sign xor divisor sign.
// - Zero flag is one when the result is all zeros and, for extend forms, Z was already one; divide sets it on a zero divisor.
// - Overflow flag set on signed overflow, cleared otherwise.
// - Carry holds add carry, subtract borrow, or shifted-out bit.
// - Bit operations use carry as one-bit accumulator, source and target.
// - Signed divide 16/8 and 32/16 giving quotient and remainder.
// - Compare subtracts operand from register and updates flags.
// - Negate replaces register by zero minus its value.
// - Zero-extend widens low byte or half, upper bits zero.
// - Sign-extend widens low byte or half, upper bits copy sign.
`timescale 1ns/1ns
`default_nettype none
module cfad_core (
    input wire logic MCLK_IN,
    input wire logic RST_B_IN,
    input wire logic OP_VALID_IN,
    input wire logic [3:0] OP_CODE_IN,
    input wire logic [1:0] OP_SIZE_IN,
    input wire logic [31:0] OP_DST_IN,
    input wire logic [31:0] OP_SRC_IN,
    input wire logic SHIFT_OUT_BIT_IN,
    input wire logic [1:0] BIT_FUNC_IN,
    input wire logic BIT_OPERAND_IN,
    input wire logic [7:0] CCR_WDATA_IN,
    input wire logic EXC_START_IN,
    input wire logic IRQ_REQ_IN,
    input wire logic NMI_REQ_IN,
    output logic [31:0] RESULT_OUT,
    output logic RESULT_WE_OUT,
    output logic [7:0] CCR_OUT,
    output logic CARRY_BIT_OUT,
    output logic IRQ_TAKE_OUT,
    output logic NMI_TAKE_OUT
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] size_mask(input logic [1:0] sz);
        logic [31:0] m;
        m = 32'hffffffff;
        if (sz == cfad_pkg::SZ_B)
            m = 32'h000000ff;
        else if (sz == cfad_pkg::SZ_W)
            m = 32'h0000ffff;
        return m;
    endfunction : size_mask

    function automatic logic msb_of(input logic [31:0] v,
                                    input logic [1:0] sz);
        logic b;
        b = v[31];
        if (sz == cfad_pkg::SZ_B)
            b = v[7];
        else if (sz == cfad_pkg::SZ_W)
            b = v[15];
        return b;
    endfunction : msb_of

    function automatic logic carry_at(input logic [31:0] a,
                                      input logic [31:0] b,
                                      input logic [31:0] s,
                                      input int pos);
        logic [32:0] x;
        x = {1'b0, a ^ b ^ s};
        return x[pos];
    endfunction : carry_at

    logic [7:0] ccr_ff;
    logic [7:0] nxt_ccr;
    logic [31:0] result_ff;
    logic [31:0] nxt_result;
    logic result_we_ff;
    logic nxt_result_we;

    // ****************************************
    // Add / subtract datapath
    // ****************************************
    logic [31:0] mask;
    logic [31:0] opa;
    logic [31:0] opb;
    logic is_sub;
    logic cin;
    logic [32:0] sum_full;
    logic [31:0] sum;
    logic carry_out;
    logic half;

    always_comb
    begin
        mask = size_mask(OP_SIZE_IN);
        is_sub = (OP_CODE_IN == cfad_pkg::OP_SUB) ||
                 (OP_CODE_IN == cfad_pkg::OP_SUBTRACT_WITH_EXTEND) ||
                 (OP_CODE_IN == cfad_pkg::OP_CMP) ||
                 (OP_CODE_IN == cfad_pkg::OP_NEG);
        cin = ((OP_CODE_IN == cfad_pkg::OP_ADD_WITH_EXTEND) ||
               (OP_CODE_IN == cfad_pkg::OP_SUBTRACT_WITH_EXTEND)) ? ccr_ff[cfad_pkg::BIT_C]
                                                   : 1'b0;
        // Negate is zero minus the destination
        opa = (OP_CODE_IN == cfad_pkg::OP_NEG) ? 32'h00000000
                                               : (OP_DST_IN & mask);
        opb = ((OP_CODE_IN == cfad_pkg::OP_NEG) ? OP_DST_IN : OP_SRC_IN)
              & mask;
        if (is_sub)
            sum_full = {1'b0, opa} - {1'b0, opb} - {32'h00000000, cin};
        else
            sum_full = {1'b0, opa} + {1'b0, opb} + {32'h00000000, cin};
        sum = sum_full[31:0] & mask;
        // Carry out taken at the operand's top; borrow uses the same bit
        case (OP_SIZE_IN)
            cfad_pkg::SZ_B:
            begin
                carry_out = carry_at(opa, opb, sum_full[31:0], 8);
                half = carry_at(opa, opb, sum_full[31:0],
                                cfad_pkg::HC_B);
            end
            cfad_pkg::SZ_W:
            begin
                carry_out = carry_at(opa, opb, sum_full[31:0], 16);
                half = carry_at(opa, opb, sum_full[31:0],
                                cfad_pkg::HC_W);
            end
            default:
            begin
                carry_out = sum_full[32];
                half = carry_at(opa, opb, sum_full[31:0],
                                cfad_pkg::HC_L);
            end
        endcase
    end

    // ****************************************
    // Signed divide
    // ****************************************
    logic [15:0] div_q;
    logic [15:0] div_r;
    logic [31:0] div_res;

    always_comb
    begin
        div_q = 16'h0000;
        div_r = 16'h0000;
        if (OP_SIZE_IN == cfad_pkg::SZ_B)
        begin
            // 16 / 8: remainder high byte, quotient low byte
            if (OP_SRC_IN[7:0] != 8'h00)
            begin
                div_q = 16'(signed'(OP_DST_IN[15:0]) /
                            signed'({{8{OP_SRC_IN[7]}}, OP_SRC_IN[7:0]}));
                div_r = 16'(signed'(OP_DST_IN[15:0]) %
                            signed'({{8{OP_SRC_IN[7]}}, OP_SRC_IN[7:0]}));
            end
            div_res = {16'h0000, div_r[7:0], div_q[7:0]};
        end
        else
        begin
            // 32 / 16: remainder high half, quotient low half
            if (OP_SRC_IN[15:0] != 16'h0000)
            begin
                div_q = 16'(signed'(OP_DST_IN) /
                            signed'({{16{OP_SRC_IN[15]}}, OP_SRC_IN[15:0]}));
                div_r = 16'(signed'(OP_DST_IN) %
                            signed'({{16{OP_SRC_IN[15]}}, OP_SRC_IN[15:0]}));
            end
            div_res = {div_r, div_q};
        end
    end

    // ****************************************
    // Result and flag selection
    // ****************************************
    logic [31:0] res;
    logic bit_res;

    always_comb
    begin
        nxt_ccr = ccr_ff;
        nxt_result = result_ff;
        nxt_result_we = 1'b0;
        res = sum;
        case (BIT_FUNC_IN)
            2'h0: bit_res = BIT_OPERAND_IN;
            2'h1: bit_res = ccr_ff[cfad_pkg::BIT_C] & BIT_OPERAND_IN;
            2'h2: bit_res = ccr_ff[cfad_pkg::BIT_C] | BIT_OPERAND_IN;
            default: bit_res = ccr_ff[cfad_pkg::BIT_C] ^ BIT_OPERAND_IN;
        endcase
        if (OP_VALID_IN)
        begin
            case (OP_CODE_IN)
                cfad_pkg::OP_ADD, cfad_pkg::OP_ADD_WITH_EXTEND, cfad_pkg::OP_SUB,
                cfad_pkg::OP_SUBTRACT_WITH_EXTEND, cfad_pkg::OP_CMP, cfad_pkg::OP_NEG:
                begin
                    nxt_ccr[cfad_pkg::BIT_H] = half;
                    nxt_ccr[cfad_pkg::BIT_N] = msb_of(sum, OP_SIZE_IN);
                    // Extend forms keep Z cleared-only for multi-word chains
                    if ((OP_CODE_IN == cfad_pkg::OP_ADD_WITH_EXTEND) ||
                        (OP_CODE_IN == cfad_pkg::OP_SUBTRACT_WITH_EXTEND))
                        nxt_ccr[cfad_pkg::BIT_Z] =
                            ccr_ff[cfad_pkg::BIT_Z] & (sum == 32'h00000000);
                    else
                        nxt_ccr[cfad_pkg::BIT_Z] =
                            (sum == 32'h00000000);
                    if (is_sub)
                        nxt_ccr[cfad_pkg::BIT_V] =
                            (msb_of(opa, OP_SIZE_IN) != msb_of(opb, OP_SIZE_IN))
                            && (msb_of(sum, OP_SIZE_IN)
                                != msb_of(opa, OP_SIZE_IN));
                    else
                        nxt_ccr[cfad_pkg::BIT_V] =
                            (msb_of(opa, OP_SIZE_IN) == msb_of(opb, OP_SIZE_IN))
                            && (msb_of(sum, OP_SIZE_IN)
                                != msb_of(opa, OP_SIZE_IN));
                    nxt_ccr[cfad_pkg::BIT_C] = carry_out;
                    // Compare updates only flags
                    nxt_result_we = (OP_CODE_IN != cfad_pkg::OP_CMP);
                end
                cfad_pkg::OP_ZERO_EXTEND_OP, cfad_pkg::OP_SIGN_EXTEND_OP:
                begin
                    if (OP_SIZE_IN == cfad_pkg::SZ_W)
                        res = {16'h0000,
                               (OP_CODE_IN == cfad_pkg::OP_SIGN_EXTEND_OP) ?
                               {8{OP_DST_IN[7]}} : 8'h00,
                               OP_DST_IN[7:0]};
                    else
                        res = {(OP_CODE_IN == cfad_pkg::OP_SIGN_EXTEND_OP) ?
                               {16{OP_DST_IN[15]}} : 16'h0000,
                               OP_DST_IN[15:0]};
                    nxt_ccr[cfad_pkg::BIT_N] = msb_of(res, OP_SIZE_IN);
                    nxt_ccr[cfad_pkg::BIT_Z] = (res == 32'h00000000);
                    nxt_ccr[cfad_pkg::BIT_V] = 1'b0;
                    nxt_result_we = 1'b1;
                end
                cfad_pkg::OP_DIVS:
                begin
                    res = div_res;
                    // N is dividend sign xor divisor sign; a zero divisor sets Z
                    // Byte form has a 16-bit dividend, word form 32 bits
                    nxt_ccr[cfad_pkg::BIT_N] =
                        msb_of(OP_DST_IN, (OP_SIZE_IN == cfad_pkg::SZ_B) ?
                               cfad_pkg::SZ_W : cfad_pkg::SZ_L) ^
                        msb_of(OP_SRC_IN, OP_SIZE_IN);
                    nxt_ccr[cfad_pkg::BIT_Z] =
                        ((OP_SRC_IN & size_mask(OP_SIZE_IN)) == 32'h00000000);
                    nxt_result_we = 1'b1;
                end
                cfad_pkg::OP_SHIFT:
                    nxt_ccr[cfad_pkg::BIT_C] = SHIFT_OUT_BIT_IN;
                cfad_pkg::OP_BITOP:
                    nxt_ccr[cfad_pkg::BIT_C] = bit_res;
                cfad_pkg::OP_LDC:
                    nxt_ccr = CCR_WDATA_IN;
                cfad_pkg::OP_AND_INTO_CONTROL:
                    nxt_ccr = ccr_ff & CCR_WDATA_IN;
                cfad_pkg::OP_ORC:
                    nxt_ccr = ccr_ff | CCR_WDATA_IN;
                cfad_pkg::OP_XOR_INTO_CONTROL:
                    nxt_ccr = ccr_ff ^ CCR_WDATA_IN;
                default:
                    nxt_ccr = ccr_ff;
            endcase
            if (nxt_result_we)
                nxt_result = res & size_mask(OP_SIZE_IN);
            if (OP_CODE_IN == cfad_pkg::OP_DIVS)
                nxt_result = res;
        end
        // Exception entry wins over any same-cycle write to the mask
        if (EXC_START_IN)
            nxt_ccr = nxt_ccr | cfad_pkg::CCR_IMASK;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_B_IN)
            ccr_ff <= cfad_pkg::CCR_RESET;
        else
            ccr_ff <= nxt_ccr;
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_B_IN)
        begin
            result_ff <= 32'h00000000;
            result_we_ff <= 1'b0;
        end
        else
        begin
            result_ff <= nxt_result;
            result_we_ff <= nxt_result_we;
        end
    end

    // ****************************************
    // Interrupt acceptance
    // ****************************************
    assign IRQ_TAKE_OUT = IRQ_REQ_IN & ~ccr_ff[cfad_pkg::BIT_I];
    assign NMI_TAKE_OUT = NMI_REQ_IN;
    assign RESULT_OUT = result_ff;
    assign RESULT_WE_OUT = result_we_ff;
    assign CCR_OUT = ccr_ff;
    assign CARRY_BIT_OUT = ccr_ff[cfad_pkg::BIT_C];
endmodule : cfad_core
`default_nettype wire

// ---- cfad_core_assertions.sv ----
// Checker: port properties of the flags and arithmetic datapath
`timescale 1ns/1ns
`default_nettype none
module cfad_chk (
    input wire logic MCLK_IN,
    input wire logic RST_B_IN,
    input wire logic OP_VALID_IN,
    input wire logic [3:0] OP_CODE_IN,
    input wire logic [1:0] OP_SIZE_IN,
    input wire logic SHIFT_OUT_BIT_IN,
    input wire logic EXC_START_IN,
    input wire logic IRQ_REQ_IN,
    input wire logic NMI_REQ_IN,
    input wire logic [31:0] RESULT_OUT,
    input wire logic RESULT_WE_OUT,
    input wire logic [7:0] CCR_OUT,
    input wire logic CARRY_BIT_OUT,
    input wire logic IRQ_TAKE_OUT,
    input wire logic NMI_TAKE_OUT
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_B_IN);
    logic fl_op, wr_op;
    // ADD_WITH_EXTEND and SUBTRACT_WITH_EXTEND are left out: their zero flag also keeps history
    assign fl_op = OP_VALID_IN && OP_CODE_IN inside {cfad_pkg::OP_ADD,
        cfad_pkg::OP_SUB, cfad_pkg::OP_NEG};
    assign wr_op = OP_VALID_IN && OP_CODE_IN != cfad_pkg::OP_CMP &&
        OP_CODE_IN inside {[cfad_pkg::OP_ADD:cfad_pkg::OP_DIVS]};
    a_irq_mask_gate: assert property (IRQ_TAKE_OUT == (IRQ_REQ_IN && !CCR_OUT[7]))
        else $error("maskable take disagrees with mask");
    a_reset_mask: assert property ($rose(RST_B_IN) |-> CCR_OUT == 8'h80)
        else $error("mask not set out of reset");
    a_nmi_always: assert property (NMI_REQ_IN |-> NMI_TAKE_OUT)
        else $error("non-maskable request refused");
    a_exc_sets_mask: assert property (EXC_START_IN |=> CCR_OUT[7])
        else $error("exception start left mask clear");
    a_cmp_no_write: assert property (OP_VALID_IN &&
        OP_CODE_IN == cfad_pkg::OP_CMP |=> !RESULT_WE_OUT)
        else $error("compare wrote its register");
    a_write_pulse: assert property (wr_op |=> RESULT_WE_OUT)
        else $error("result write missing");
    a_zero_flag: assert property (fl_op |=> CCR_OUT[2] == (RESULT_OUT == 0))
        else $error("zero flag differs from result");
    // Size comes from the op edge; the result shows one edge later
    a_sign_flag: assert property (fl_op |=> CCR_OUT[3] ==
        ($past(OP_SIZE_IN) == 2'h0 ? RESULT_OUT[7] :
        $past(OP_SIZE_IN) == 2'h1 ? RESULT_OUT[15] : RESULT_OUT[31]))
        else $error("negative flag differs from sign");
    a_shift_carry: assert property (OP_VALID_IN &&
        OP_CODE_IN == cfad_pkg::OP_SHIFT |=> CARRY_BIT_OUT == $past(SHIFT_OUT_BIT_IN))
        else $error("shifted bit not in carry");
    a_carry_mirror: assert property (CARRY_BIT_OUT == CCR_OUT[0])
        else $error("carry output differs from flag");
    a_zero_extend_op_upper: assert property (OP_VALID_IN && OP_SIZE_IN == 2'h2 &&
        OP_CODE_IN == cfad_pkg::OP_ZERO_EXTEND_OP |=> RESULT_OUT[31:16] == 16'h0)
        else $error("zero extend left upper bits set");
    c_cmp: cover property (OP_VALID_IN && OP_CODE_IN == cfad_pkg::OP_CMP);
    c_div: cover property (OP_VALID_IN && OP_CODE_IN == cfad_pkg::OP_DIVS);
    c_exc: cover property (EXC_START_IN ##1 CCR_OUT[7]);
endmodule : cfad_chk
bind cfad_core cfad_chk u_chk (.MCLK_IN, .RST_B_IN, .OP_VALID_IN,
    .OP_CODE_IN, .OP_SIZE_IN, .SHIFT_OUT_BIT_IN, .EXC_START_IN, .IRQ_REQ_IN,
    .NMI_REQ_IN, .RESULT_OUT, .RESULT_WE_OUT, .CCR_OUT, .CARRY_BIT_OUT,
    .IRQ_TAKE_OUT, .NMI_TAKE_OUT);
`default_nettype wire

// ---- cfad_dec_model.sv ----
// Model: decoder issuing one operation a cycle to the datapath
`timescale 1ns/1ns
`default_nettype none
module cfad_dec_model (
    input wire logic clk_in,
    output logic vld_out,
    output logic [3:0] code_out,
    output logic [1:0] size_out,
    output logic [31:0] dst_out,
    output logic [31:0] src_out,
    output logic shb_out,
    output logic [1:0] bfn_out,
    output logic bop_out,
    output logic [7:0] wd_out
);
    // ****
    // Issue
    // ****
    initial
    begin
        {vld_out, code_out, size_out, dst_out, src_out} = '0;
        {shb_out, bfn_out, bop_out, wd_out} = '0;
    end
    // Caller stands on a falling edge; the op is held until the next call,
    // so calls in a row give back-to-back ops with no gap
    task automatic issue(input logic [3:0] o, input logic [1:0] z,
        input logic [31:0] d, input logic [31:0] s);
        {vld_out, code_out, size_out, dst_out, src_out} = {1'b1, o, z, d, s};
        {shb_out, bop_out, bfn_out, wd_out} = {d[0], d[0], s[1:0], d[7:0]};
        @(negedge clk_in);
    endtask : issue
    task automatic idle();
        vld_out = 1'b0;
        @(negedge clk_in);
    endtask : idle
endmodule : cfad_dec_model
`default_nettype wire

// ---- test_cpu_flags_arith_datapath.sv ----
// Testbench: self-checking run of the flags and arithmetic datapath
`timescale 1ns/1ns
`default_nettype none
module test_cpu_flags_arith_datapath;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic exc = 1'b0;
    logic irq = 1'b0;
    logic nmi = 1'b0;
    logic vld, shb, bop, we, cbit, itk, ntk;
    logic [1:0] sz, bfn, z;
    logic [3:0] code, o;
    logic [7:0] wd, condition_code_register, mc, k;
    logic [31:0] dst, src, res;
    logic [31:0] rnd = 32'h1e;
    int error_cnt = 0;
    int n_checks = 0;
    logic [3:0] ops [6] = '{cfad_pkg::OP_ADD, cfad_pkg::OP_ADD_WITH_EXTEND,
        cfad_pkg::OP_SUB, cfad_pkg::OP_SUBTRACT_WITH_EXTEND, cfad_pkg::OP_CMP, cfad_pkg::OP_NEG};
    always #5 clk = ~clk;
    cfad_core dut (.MCLK_IN(clk), .RST_B_IN(rst_b), .OP_VALID_IN(vld),
        .OP_CODE_IN(code), .OP_SIZE_IN(sz), .OP_DST_IN(dst), .OP_SRC_IN(src),
        .SHIFT_OUT_BIT_IN(shb), .BIT_FUNC_IN(bfn), .BIT_OPERAND_IN(bop),
        .CCR_WDATA_IN(wd), .EXC_START_IN(exc), .IRQ_REQ_IN(irq),
        .NMI_REQ_IN(nmi), .RESULT_OUT(res), .RESULT_WE_OUT(we), .CCR_OUT(condition_code_register),
        .CARRY_BIT_OUT(cbit), .IRQ_TAKE_OUT(itk), .NMI_TAKE_OUT(ntk));
    cfad_dec_model u_dec (.clk_in(clk), .vld_out(vld), .code_out(code),
        .size_out(sz), .dst_out(dst), .src_out(src), .shb_out(shb),
        .bfn_out(bfn), .bop_out(bop), .wd_out(wd));
    // ****
    // Expectations
    // ****
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [39:0] ex(input logic [3:0] op, input logic [1:0] zs,
        input logic [31:0] d, input logic [31:0] s, input logic [7:0] c);
        logic [32:0] r, m;
        logic [31:0] a, b, q;
        logic sb, x;
        int w;
        w = zs == 2'h0 ? 8 : zs == 2'h1 ? 16 : 32;
        m = (33'h1 << w) - 33'h1;
        sb = op inside {[cfad_pkg::OP_SUB:cfad_pkg::OP_NEG]};
        x = op inside {cfad_pkg::OP_ADD_WITH_EXTEND, cfad_pkg::OP_SUBTRACT_WITH_EXTEND};
        a = op == cfad_pkg::OP_NEG ? 32'h0 : d & m[31:0];
        b = (op == cfad_pkg::OP_NEG ? d : s) & m[31:0];
        r = sb ? {1'b0, a} - b - (x & c[0]) : {1'b0, a} + b + (x & c[0]);
        q = r[31:0] & m[31:0];
        c[5] = 1'((a ^ b ^ r[31:0]) >> (w - 4));
        c[3] = q[w - 1];
        c[2] = q == 32'h0 && (!x || c[2]);
        c[1] = (a[w - 1] ^ b[w - 1] ^ !sb) && q[w - 1] != a[w - 1];
        c[0] = r[w];
        return {c, q};
    endfunction : ex
    function automatic logic [39:0] exx(input logic [3:0] op, input logic [1:0] zs,
        input logic [31:0] d, input logic [7:0] c);
        logic [31:0] q;
        logic g;
        g = op == cfad_pkg::OP_SIGN_EXTEND_OP && (zs == 2'h1 ? d[7] : d[15]);
        q = zs == 2'h1 ? {16'h0, {8{g}}, d[7:0]} : {{16{g}}, d[15:0]};
        c[3:1] = {zs == 2'h1 ? q[15] : q[31], q == 32'h0, 1'b0};
        return {c, q};
    endfunction : exx
    task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] e);
        n_checks++;
        if (got !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, got);
        end
    endtask : chk
    task automatic run(input logic [3:0] op, input logic [1:0] zs,
        input logic [31:0] d, input logic [31:0] s, input logic [39:0] e, input logic wr);
        u_dec.issue(op, zs, d, s);
        chk("ccr", condition_code_register, e[39:32]);
        chk("write", {we, wr ? res : 32'h0}, {wr, wr ? e[31:0] : 32'h0});
        mc = e[39:32];
    endtask : run
    task automatic ar(input logic [3:0] op, input logic [1:0] zs,
        input logic [31:0] d, input logic [31:0] s);
        run(op, zs, d, s, ex(op, zs, d, s, mc), op != cfad_pkg::OP_CMP);
    endtask : ar
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    // ****
    // Tests
    // ****
    initial
    begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        mc = 8'h80;
        chk("reset", {we, condition_code_register, res}, {1'b0, mc, 32'h0});
        ar(cfad_pkg::OP_ADD, 2'h0, 32'h0f, 32'h1);
        ar(cfad_pkg::OP_ADD, 2'h1, 32'h0fff, 32'h1);
        ar(cfad_pkg::OP_ADD, 2'h2, 32'h0fffffff, 32'h1);
        ar(cfad_pkg::OP_SUB, 2'h0, 32'h0, 32'h1);
        ar(cfad_pkg::OP_ADD_WITH_EXTEND, 2'h0, 32'h7f, 32'h0);
        ar(cfad_pkg::OP_NEG, 2'h2, 32'h80000000, 32'h0);
        ar(cfad_pkg::OP_CMP, 2'h1, 32'h1234, 32'h1234);
        ar(cfad_pkg::OP_SUBTRACT_WITH_EXTEND, 2'h0, 32'h1, 32'h1);
        for (int i = 0; i < 60; i++)
        begin
            rnd = lfsr(rnd);
            o = ops[rnd[2:0] % 3'h6];
            z = o inside {cfad_pkg::OP_ADD_WITH_EXTEND, cfad_pkg::OP_SUBTRACT_WITH_EXTEND} ? 2'h0 : rnd[4:3] % 2'h3;
            k = rnd[12:5];
            rnd = lfsr(lfsr(rnd));
            ar(o, z, {k, rnd[23:0]}, rnd);
        end
        $display("arith done");
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            o = i[0] ? cfad_pkg::OP_SIGN_EXTEND_OP : cfad_pkg::OP_ZERO_EXTEND_OP;
            z = i[1] ? 2'h2 : 2'h1;
            run(o, z, rnd, 32'h0, exx(o, z, rnd, mc), 1'b1);
        end
        run(cfad_pkg::OP_DIVS, 2'h0, 32'hfff9, 32'h2, {mc[7:4], 2'h2, mc[1:0], 32'hfffd}, 1'b1);
        run(cfad_pkg::OP_DIVS, 2'h1, 32'h64, 32'hfff6, {mc[7:4], 2'h2, mc[1:0], 32'hfff6}, 1'b1);
        run(cfad_pkg::OP_DIVS, 2'h0, 32'h11, 32'h0, {mc[7:4], 2'h1, mc[1:0], 32'h0}, 1'b1);
        $display("extend divide done");
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            k = i == 0 ? rnd[7:0] : i == 1 ? mc & rnd[7:0] : i == 2 ? mc | rnd[7:0] : mc ^ rnd[7:0];
            run(4'(cfad_pkg::OP_LDC + i), 2'h0, rnd & 32'hff, 32'h0, {k, 32'h0}, 1'b0);
        end
        run(cfad_pkg::OP_LDC, 2'h0, 32'h0, 32'h0, 40'h0, 1'b0);
        // Idle first, or the held load would run again in the exception cycle
        u_dec.idle();
        {irq, nmi} = 2'h3;
        #1;
        chk("take_open", {itk, ntk}, 2'h3);
        exc = 1'b1;
        @(negedge clk);
        exc = 1'b0;
        #1;
        chk("take_masked", {condition_code_register, itk, ntk}, 10'h201);
        {irq, nmi} = 2'h0;
        mc = 8'h80;
        run(cfad_pkg::OP_SHIFT, 2'h0, 32'h1, 32'h0, {mc[7:1], 1'b1, 32'h0}, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            k[0] = i[1:0] == 0 ? rnd[0] : i[1:0] == 1 ? mc[0] & rnd[0] :
                i[1:0] == 2 ? mc[0] | rnd[0] : mc[0] ^ rnd[0];
            run(cfad_pkg::OP_BITOP, 2'h0, rnd, i, {mc[7:1], k[0], 32'h0}, 1'b0);
        end
        $display("control bit done");
        u_dec.idle();
        summarize();
    end
    initial
    begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        summarize();
    end
endmodule : test_cpu_flags_arith_datapath
`default_nettype wire
